// File: pfl_pkg.sv
// constants, register map and carrier types of the pwm fault, lockout and trigger block
package pfl_pkg;

	// ------------------------------------------------------------------
	// register byte addresses on the apb bus
	// ------------------------------------------------------------------
	localparam logic [7:0] ADDR_FAULT_CFG = 8'h00; // fault_config
	localparam logic [7:0] ADDR_CTRL2     = 8'h04; // pwm_control_second
	localparam logic [7:0] ADDR_CMP_LO    = 8'h08; // trigger_compare_low
	localparam logic [7:0] ADDR_CMP_HI    = 8'h0c; // trigger_compare_high
	localparam logic [7:0] ADDR_PER_BUF   = 8'h10; // period buffer
	localparam logic [7:0] ADDR_DUTY0     = 8'h14; // duty buffers 0..2
	localparam logic [7:0] ADDR_ACT_PER   = 8'h20; // active period, read only
	localparam logic [7:0] ADDR_STEP      = 8'h04; // spacing of duty words

	// ------------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------------
	localparam int FC_BRK    = 7; // breakpoint_fault_enable
	localparam int FC_STAT   = 2; // fault_status
	localparam int FC_MODE   = 1; // fault_mode
	localparam int FC_EN     = 0; // fault_input_enable
	localparam int C2_PS_LSB = 4; // trigger_postscale, four bits
	localparam int C2_DIR    = 3; // trigger_direction
	localparam int C2_UPDATE_DISABLE   = 1; // update_disable
	localparam int C2_OSYNC  = 0; // output sync, stored only

	// ------------------------------------------------------------------
	// widths and reset values
	// ------------------------------------------------------------------
	localparam int TB_W     = 12;
	localparam int DUTY_W   = 14;
	localparam int NUM_DUTY = 3;
	localparam int NUM_PINS = 6;
	localparam logic [3:0]  PS_RST   = 4'h0;
	localparam logic [11:0] TB_RST   = 12'h000;
	localparam logic [13:0] DUTY_RST = 14'h0000;
	localparam logic [31:0] RD_ZERO  = 32'h0000_0000;

	// ------------------------------------------------------------------
	// timing: pin to forced outputs, in pclk cycles
	// ------------------------------------------------------------------
	localparam int FAULT_LATENCY = 3;

	// ------------------------------------------------------------------
	// carrier types
	// ------------------------------------------------------------------
	typedef struct packed {
		logic [TB_W-1:0] count;        // time_base_count
		logic            count_down;   // counting downward
		logic            updown_mode;  // continuous up/down mode
		logic            period_start; // one-cycle pulse per period
	} pfl_tb_t;

	typedef struct packed {
		logic [TB_W-1:0]                  period;
		logic [NUM_DUTY-1:0][DUTY_W-1:0]  duty;
	} pfl_active_t;

endpackage : pfl_pkg

// File: pfl_fault_lockout.sv
// pwm fault protection, update lockout and special event trigger
`timescale 1ns/1ps
module pfl_fault_lockout (
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [7:0]            paddr,
	input  wire logic [31:0]           pwdata,
	output logic      [31:0]           prdata,
	output logic                       pready,
	output logic                       pslverr,
	input  wire pfl_pkg::pfl_tb_t      time_base,
	input  wire logic                  fault_input_n,
	input  wire logic                  breakpoint,
	input  wire logic                  high_side_polarity,
	input  wire logic                  low_side_polarity,
	input  wire logic [5:0]            pwm_drive,
	output logic      [5:0]            pwm_out,
	output logic                       outputs_forced,
	output logic                       trigger_pulse,
	output pfl_pkg::pfl_active_t       active_values
);

	// ------------------------------------------------------------------
	// state
	// ------------------------------------------------------------------
	logic        brk_en_reg, mode_reg, en_reg, status_reg;
	logic [3:0]  ps_reg;
	logic        dir_reg, update_disable_reg, osync_reg;
	logic [7:0]  cmp_lo_reg;
	logic [3:0]  cmp_hi_reg;
	logic [11:0] cmp_act_reg, per_buf_reg, act_per_reg;
	logic [13:0] duty_buf_reg [pfl_pkg::NUM_DUTY];
	logic [13:0] act_duty_reg [pfl_pkg::NUM_DUTY];
	logic        meta_reg, sync_reg, block_reg, forced_reg;
	logic [5:0]  pwm_reg;
	logic        match_q_reg, trig_reg;
	logic [3:0]  post_cnt_reg;
	logic        pready_reg, pslverr_reg;
	logic [31:0] prdata_reg;

	// ------------------------------------------------------------------
	// apb decode
	// ------------------------------------------------------------------
	wire        take     = psel & penable & ~pready_reg;
	wire        wr       = psel & penable & pready_reg & pwrite;
	wire        sel_fc   = paddr == pfl_pkg::ADDR_FAULT_CFG;
	wire        sel_c2   = paddr == pfl_pkg::ADDR_CTRL2;
	wire        sel_lo   = paddr == pfl_pkg::ADDR_CMP_LO;
	wire        sel_hi   = paddr == pfl_pkg::ADDR_CMP_HI;
	wire        sel_per  = paddr == pfl_pkg::ADDR_PER_BUF;
	wire        sel_act  = paddr == pfl_pkg::ADDR_ACT_PER;
	wire [7:0]  duty_off = paddr - pfl_pkg::ADDR_DUTY0;
	wire [1:0]  duty_idx = duty_off[3:2];
	wire        sel_duty = (paddr >= pfl_pkg::ADDR_DUTY0) &&
	                       (paddr < pfl_pkg::ADDR_ACT_PER) &&
	                       (paddr[1:0] == 2'h0);
	wire        mapped   = sel_fc | sel_c2 | sel_lo | sel_hi | sel_per |
	                       sel_act | sel_duty;
	wire        wr_fc    = wr & sel_fc;
	wire        wr_c2    = wr & sel_c2;
	wire        cmp_wr   = wr & (sel_lo | sel_hi);

	// read multiplexer, unused bits zero
	wire [31:0] rd_fc   = {24'h000000, brk_en_reg, 4'h0, status_reg,
	                       mode_reg, en_reg};
	wire [31:0] rd_c2   = {24'h000000, ps_reg, dir_reg, 1'b0, update_disable_reg,
	                       osync_reg};
	wire [31:0] rd_mux  =
		sel_fc   ? rd_fc :
		sel_c2   ? rd_c2 :
		sel_lo   ? {24'h000000, cmp_lo_reg} :
		sel_hi   ? {28'h0000000, cmp_hi_reg} :
		sel_per  ? {20'h00000, per_buf_reg} :
		sel_act  ? {20'h00000, act_per_reg} :
		sel_duty ? {18'h00000, duty_buf_reg[duty_idx]} :
		pfl_pkg::RD_ZERO;

	// one wait cycle, then ready with data or error
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_reg  <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg  <= pfl_pkg::RD_ZERO;
		end else begin
			pready_reg  <= take;
			pslverr_reg <= take & ~mapped;
			prdata_reg  <= take ? rd_mux : prdata_reg;
		end
	end

	// ------------------------------------------------------------------
	// configuration registers
	// ------------------------------------------------------------------
	wire update_disable_fall = wr_c2 & update_disable_reg & ~pwdata[pfl_pkg::C2_UPDATE_DISABLE];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			brk_en_reg <= 1'b0;
			mode_reg   <= 1'b0;
			en_reg     <= 1'b0;
			ps_reg     <= pfl_pkg::PS_RST;
			dir_reg    <= 1'b0;
			update_disable_reg   <= 1'b0;
			osync_reg  <= 1'b0;
		end else begin
			if (wr_fc) begin
				brk_en_reg <= pwdata[pfl_pkg::FC_BRK];
				mode_reg   <= pwdata[pfl_pkg::FC_MODE];
				en_reg     <= pwdata[pfl_pkg::FC_EN];
			end
			if (wr_c2) begin
				ps_reg    <= pwdata[pfl_pkg::C2_PS_LSB +: 4];
				dir_reg   <= pwdata[pfl_pkg::C2_DIR];
				update_disable_reg  <= pwdata[pfl_pkg::C2_UPDATE_DISABLE];
				osync_reg <= pwdata[pfl_pkg::C2_OSYNC];
			end
		end
	end

	// ------------------------------------------------------------------
	// double buffers and their transfer to active use
	// ------------------------------------------------------------------
	wire load_act = (time_base.period_start & ~update_disable_reg) | update_disable_fall;

	// period and compare buffers; compare moves over every period start
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			per_buf_reg <= pfl_pkg::TB_RST;
			act_per_reg <= pfl_pkg::TB_RST;
			cmp_lo_reg  <= 8'h00;
			cmp_hi_reg  <= 4'h0;
			cmp_act_reg <= pfl_pkg::TB_RST;
		end else begin
			if (wr & sel_per)
				per_buf_reg <= pwdata[11:0];
			if (load_act)
				act_per_reg <= per_buf_reg;
			if (wr & sel_lo)
				cmp_lo_reg <= pwdata[7:0];
			if (wr & sel_hi)
				cmp_hi_reg <= pwdata[3:0];
			if (time_base.period_start)
				cmp_act_reg <= {cmp_hi_reg, cmp_lo_reg};
		end
	end

	// duty buffers, one per channel
	for (genvar g = 0; g < pfl_pkg::NUM_DUTY; g++) begin : g_duty
		wire hit = wr & sel_duty & (duty_idx == 2'(g));
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				duty_buf_reg[g] <= pfl_pkg::DUTY_RST;
				act_duty_reg[g] <= pfl_pkg::DUTY_RST;
			end else begin
				if (hit)
					duty_buf_reg[g] <= pwdata[13:0];
				if (load_act)
					act_duty_reg[g] <= duty_buf_reg[g];
			end
		end
	end
	// active values packed in struct order, channel two first
	assign active_values = {act_per_reg, act_duty_reg[2], act_duty_reg[1],
	                        act_duty_reg[0]};

	// ------------------------------------------------------------------
	// fault path
	// ------------------------------------------------------------------
	// two-stage synchroniser on the wired-or active-low pin
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_reg <= 1'b1;
			sync_reg <= 1'b1;
		end else begin
			meta_reg <= fault_input_n;
			sync_reg <= meta_reg;
		end
	end

	wire fault_in  = en_reg & ~sync_reg;
	wire brk_fault = brk_en_reg & breakpoint;
	wire fault_now = fault_in | brk_fault;
	wire sw_clear  = wr_fc & ~mode_reg & ~pwdata[pfl_pkg::FC_STAT];
	wire auto_clr  = mode_reg & time_base.period_start;
	wire release_ok = time_base.period_start & (mode_reg | ~status_reg);
	wire force_now = fault_now | block_reg;

	// status: a fault on the pin in the clearing cycle wins; a breakpoint fault does not set status
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			status_reg <= 1'b0;
		else if (fault_in)
			status_reg <= 1'b1;
		else if (auto_clr | sw_clear)
			status_reg <= 1'b0;
	end

	// output block held to a period boundary after the fault ends and, in latched mode, after status is cleared
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			block_reg <= 1'b0;
		else if (fault_now)
			block_reg <= 1'b1;
		else if (release_ok)
			block_reg <= 1'b0;
	end

	// per-pin polarity: odd pins high side, even pins low side
	logic [5:0] pol;
	logic [5:0] pin_next;
	for (genvar p = 0; p < pfl_pkg::NUM_PINS; p++) begin : g_pin
		assign pol[p]      = (p % 2 == 1) ? high_side_polarity :
		                     low_side_polarity;
		assign pin_next[p] = ~((pwm_drive[p] & ~force_now) ^ pol[p]);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pwm_reg    <= 6'h00;
			forced_reg <= 1'b0;
		end else begin
			pwm_reg    <= pin_next;
			forced_reg <= force_now;
		end
	end

	// ------------------------------------------------------------------
	// special event trigger and postscaler
	// ------------------------------------------------------------------
	wire dir_ok  = ~time_base.updown_mode |
	               (dir_reg == time_base.count_down);
	wire match   = (time_base.count == cmp_act_reg) &
	               (cmp_act_reg != pfl_pkg::TB_RST) & dir_ok;
	wire evt     = match & ~match_q_reg;
	wire ps_hit  = post_cnt_reg == ps_reg;

	// count events; every ps_reg+1 events give one pulse
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			match_q_reg  <= 1'b0;
			post_cnt_reg <= 4'h0;
			trig_reg     <= 1'b0;
		end else begin
			match_q_reg <= match;
			trig_reg    <= evt & ~cmp_wr & ps_hit;
			if (cmp_wr)
				post_cnt_reg <= 4'h0;
			else if (evt)
				post_cnt_reg <= ps_hit ? 4'h0 : post_cnt_reg + 4'h1;
		end
	end

	// ------------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------------
	assign prdata         = prdata_reg;
	assign pready         = pready_reg;
	assign pslverr        = pslverr_reg;
	assign pwm_out        = pwm_reg;
	assign outputs_forced = forced_reg;
	assign trigger_pulse  = trig_reg;

	// ------------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	brk_fault_a:
	assert property (brk_en_reg && breakpoint |=> outputs_forced)
		else $error("breakpoint fault did not force outputs");
	cfg_unimpl_a:
	assert property (pready_reg && sel_fc && !pwrite |-> prdata[6:3] == 4'h0)
		else $error("unimplemented fault config bits not zero");
	status_set_a:
	assert property (fault_in |=> status_reg)
		else $error("fault status not set by fault");
	auto_clear_a:
	assert property (mode_reg && time_base.period_start && !fault_in
		|=> !status_reg)
		else $error("cycle mode status not cleared at period start");
	pins_off_a:
	assert property (fault_now |=> pwm_out == ~pol && outputs_forced)
		else $error("pins not inactive during fault");
	latched_hold_a:
	assert property (!mode_reg && status_reg && !sw_clear |=> status_reg)
		else $error("latched status cleared without software");
	latched_block_a:
	assert property (!mode_reg && status_reg && block_reg |=> block_reg)
		else $error("latched outputs released before status clear");
	sw_clear_a:
	assert property (sw_clear && !fault_in |=> !status_reg)
		else $error("software clear of latched status ignored");
	period_release_a:
	assert property (!mode_reg && !status_reg && !fault_now &&
		time_base.period_start |=> !block_reg)
		else $error("latched outputs not released at period start");
	forced_level_a:
	assert property (outputs_forced |-> pwm_out == ~$past(pol))
		else $error("forced pins not at inactive polarity level");
	fault_ignore_a:
	assert property (!en_reg && !status_reg && !brk_en_reg && !block_reg
		|=> !status_reg && !outputs_forced)
		else $error("disabled fault input had an effect");
	lockout_a:
	assert property (update_disable_reg && !update_disable_fall |=> $stable(act_per_reg)
		&& $stable(act_duty_reg[0]))
		else $error("active value changed under update lockout");
	atomic_load_a:
	assert property (update_disable_fall |=> act_per_reg == $past(per_buf_reg)
		&& act_duty_reg[2] == $past(duty_buf_reg[2]))
		else $error("lockout release did not load buffers");
	zero_cmp_a:
	assert property (cmp_act_reg == pfl_pkg::TB_RST |=> !trigger_pulse)
		else $error("trigger with zero compare");
	postscale_a:
	assert property (trigger_pulse |-> $past(post_cnt_reg) == $past(ps_reg)
		&& $past(evt))
		else $error("trigger not on postscale terminal count");
	cmp_clear_a:
	assert property (cmp_wr |=> post_cnt_reg == 4'h0 && !trigger_pulse)
		else $error("compare write did not clear postscaler");
	fault_latency_a:
	assert property ((en_reg && !fault_input_n)[*3] |=> outputs_forced)
		else $error("fault not forced within three cycles");

	// trigger and buffer checks
	trig_match_a:
	assert property (trigger_pulse |->
		$past(time_base.count) == $past(cmp_act_reg))
		else $error("trigger without count match");
	trig_phase_a:
	assert property (trigger_pulse && $past(time_base.updown_mode) |->
		$past(time_base.count_down) == $past(dir_reg))
		else $error("trigger in wrong count phase");
	trig_single_a:
	assert property (trigger_pulse |=> !trigger_pulse)
		else $error("trigger pulse longer than one cycle");
	buf_hold_a:
	assert property (wr && sel_per && !load_act |=> $stable(act_per_reg))
		else $error("period write reached active value directly");

	latched_fault_c: cover property (!mode_reg && status_reg ##1 sw_clear);
	cbc_release_c:   cover property (mode_reg && block_reg ##1 !block_reg);
	trigger_c:       cover property (trigger_pulse && ps_reg != 4'h0);
	update_disable_release_c:  cover property (update_disable_fall);
	trig_down_c:     cover property (trigger_pulse && time_base.count_down);

endmodule : pfl_fault_lockout

// File: pfl_far_side.sv
// far side model: pwm time base and wired-or fault source
`timescale 1ns/1ps
module pfl_far_side #(
	parameter int PER = 16
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        updown,
	input  wire logic        fault_req,
	output pfl_pkg::pfl_tb_t tbv,
	output wire logic        fault_n
);
	logic [11:0] cnt_reg;
	logic        down_reg;

	// ------------------------------------------------------------
	// time base: saw or triangle, period starts at count zero
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_reg  <= 12'h000;
			down_reg <= 1'b0;
		end else if (!updown) begin
			cnt_reg  <= (cnt_reg == 12'(PER)) ? 12'h000 : cnt_reg + 12'h001;
			down_reg <= 1'b0;
		end else if (!down_reg) begin
			cnt_reg  <= cnt_reg + 12'h001;
			down_reg <= (cnt_reg + 12'h001 == 12'(PER));
		end else begin
			cnt_reg  <= cnt_reg - 12'h001;
			down_reg <= (cnt_reg != 12'h001);
		end
	end

	// struct out; mode only switched right after a period start
	assign tbv = '{cnt_reg, down_reg, updown, cnt_reg == 12'h000};

	// pulled-up line, any source pulls it low
	assign fault_n = fault_req ? 1'b0 : 1'b1;
endmodule : pfl_far_side

// File: tb_pwm_fault_lockout_trigger.sv
// testbench of the pwm fault, lockout and trigger block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin \
	n_mismatch++; $display("BAD %s exp %h got %h", nm, e, g); end end
module tb_pwm_fault_lockout_trigger;
	logic                 pclk, presetn, psel, penable, pwrite;
	logic                 pready, pslverr, fault_req, fault_n, brk;
	logic                 hp, lp, updown, trig, forced;
	logic [7:0]           paddr;
	logic [31:0]          pwdata, prdata;
	logic [5:0]           drv, pins, polv;
	logic [32:0]          exp_rd;
	logic [32:0]          rdq[$];
	logic [11:0]          cmp_v, exp_cnt, p1, p2;
	logic [13:0]          d1, d2;
	logic [3:0]           ps;
	logic [3:0]           psl[4] = '{4'h0, 4'h1, 4'h6, 4'hf};
	int                   n_mismatch, checks_done, pulses;
	pfl_pkg::pfl_tb_t     tbv;
	pfl_pkg::pfl_active_t act;

	assign polv = {hp, lp, hp, lp, hp, lp};

	pfl_fault_lockout uut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .time_base(tbv),
		.fault_input_n(fault_n), .breakpoint(brk), .high_side_polarity(hp),
		.low_side_polarity(lp), .pwm_drive(drv), .pwm_out(pins),
		.outputs_forced(forced), .trigger_pulse(trig), .active_values(act));
	pfl_far_side #(.PER(16)) far (.pclk(pclk), .presetn(presetn),
		.updown(updown), .fault_req(fault_req), .tbv(tbv), .fault_n(fault_n));

	// ------------------------------------------------------------
	// clock, tasks and monitors
	// ------------------------------------------------------------
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	// apb master: holds the request until pready is seen high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr
	// read notes {pslverr, prdata} expected in the queue
	task automatic rd(input logic [7:0] a, input logic [32:0] e);
		rdq.push_back(e);
		apb(1'b0, a, 32'h0000_0000);
	endtask : rd
	task automatic wait_ps(input int n);
		repeat (n) begin
			@(posedge pclk);
			while (tbv.period_start !== 1'b1) @(posedge pclk);
		end
	endtask : wait_ps
	task automatic settle(input int n);
		repeat (n) @(posedge pclk);
		#1;
	endtask : settle
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : give_verdict

	// read results are taken off the queue as they complete
	always @(posedge pclk) begin
		if (psel && penable && pready === 1'b1 && !pwrite) begin
			exp_rd = rdq.pop_front();
			`CHK("read", exp_rd, {pslverr, prdata})
		end
	end
	// trigger pulses counted; count must sit one step past compare
	always @(posedge pclk) begin
		if (trig === 1'b1) begin
			pulses++;
			`CHK("trig_count", exp_cnt, tbv.count)
		end
	end
	initial begin
		#100us;
		n_mismatch++;
		give_verdict();
	end

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		void'($urandom(10179));
		{presetn, psel, penable, pwrite, fault_req, brk, updown} = 7'h00;
		{paddr, pwdata} = 40'h00_0000_0000;
		drv = 6'($urandom);
		{hp, lp} = 2'($urandom);
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		// reset values, unmapped address, reserved bits
		rd(pfl_pkg::ADDR_FAULT_CFG, 33'h0);
		rd(pfl_pkg::ADDR_CTRL2, 33'h0);
		rd(8'h40, 33'h1_0000_0000);
		wr(pfl_pkg::ADDR_FAULT_CFG, 32'h0000_00ff);
		rd(pfl_pkg::ADDR_FAULT_CFG, 33'h083);
		// disabled fault input is ignored
		wr(pfl_pkg::ADDR_FAULT_CFG, 32'h0000_0002);
		fault_req <= 1'b1;
		settle(6);
		`CHK("forced", 1'b0, forced)
		rd(pfl_pkg::ADDR_FAULT_CFG, 33'h002);
		fault_req <= 1'b0;
		// cycle-by-cycle mode
		wr(pfl_pkg::ADDR_FAULT_CFG, 32'h0000_0003);
		wait_ps(1);
		fault_req <= 1'b1;
		settle(pfl_pkg::FAULT_LATENCY);
		`CHK("forced", 1'b1, forced)
		`CHK("pins", ~polv, pins)
		rd(pfl_pkg::ADDR_FAULT_CFG, 33'h007);
		wait_ps(1);
		fault_req <= 1'b0;
		settle(8);
		`CHK("forced", 1'b1, forced)
		wait_ps(1);
		settle(2);
		`CHK("forced", 1'b0, forced)
		`CHK("pins", ~(drv ^ polv), pins)
		rd(pfl_pkg::ADDR_FAULT_CFG, 33'h003);
		// latched mode needs a software clear
		wr(pfl_pkg::ADDR_FAULT_CFG, 32'h0000_0001);
		fault_req <= 1'b1;
		settle(5);
		@(posedge pclk);
		fault_req <= 1'b0;
		wait_ps(2);
		settle(1);
		`CHK("forced", 1'b1, forced)
		rd(pfl_pkg::ADDR_FAULT_CFG, 33'h005);
		wr(pfl_pkg::ADDR_FAULT_CFG, 32'h0000_0001);
		wait_ps(1);
		settle(2);
		`CHK("forced", 1'b0, forced)
		rd(pfl_pkg::ADDR_FAULT_CFG, 33'h001);
		// breakpoint as a fault, then with the enable off
		wr(pfl_pkg::ADDR_FAULT_CFG, 32'h0000_0080);
		brk <= 1'b1;
		settle(1);
		`CHK("forced", 1'b1, forced)
		@(posedge pclk);
		brk <= 1'b0;
		wait_ps(1);
		wr(pfl_pkg::ADDR_FAULT_CFG, 32'h0000_0000);
		brk <= 1'b1;
		settle(3);
		`CHK("forced", 1'b0, forced)
		@(posedge pclk);
		brk <= 1'b0;
		// buffered period and duty, then an atomic update
		p1 = 12'($urandom);
		d1 = 14'($urandom);
		wr(pfl_pkg::ADDR_PER_BUF, {20'h0, p1});
		wr(pfl_pkg::ADDR_DUTY0, {18'h0, d1});
		wait_ps(1);
		settle(1);
		`CHK("period", p1, act.period)
		rd(pfl_pkg::ADDR_ACT_PER, {21'h0, p1});
		wr(pfl_pkg::ADDR_CTRL2, 32'h0000_0002);
		p2 = 12'($urandom);
		d2 = 14'($urandom);
		wr(pfl_pkg::ADDR_PER_BUF, {20'h0, p2});
		wr(pfl_pkg::ADDR_DUTY0, {18'h0, d2});
		wr(pfl_pkg::ADDR_DUTY0 + pfl_pkg::ADDR_STEP, {18'h0, ~d2});
		wr(pfl_pkg::ADDR_ACT_PER - pfl_pkg::ADDR_STEP, {18'h0, d2});
		wait_ps(2);
		settle(1);
		`CHK("period", p1, act.period)
		`CHK("duty0", d1, act.duty[0])
		`CHK("duty2", 14'h0000, act.duty[2])
		wr(pfl_pkg::ADDR_CTRL2, 32'h0000_0000);
		#1;
		`CHK("period", p2, act.period)
		`CHK("duty0", d2, act.duty[0])
		`CHK("duty1", ~d2, act.duty[1])
		`CHK("duty2", d2, act.duty[2])
		rd(pfl_pkg::ADDR_DUTY0 + pfl_pkg::ADDR_STEP, {19'h0, ~d2});
		// trigger: postscale, direction and mode per table entry
		for (int i = 0; i < 4; i++) begin
			ps = psl[i];
			wr(pfl_pkg::ADDR_CMP_LO, 32'h0);
			wr(pfl_pkg::ADDR_CMP_HI, 32'h0);
			wait_ps(1);
			updown <= ps[0];
			cmp_v = 12'(8 + $urandom_range(6));
			exp_cnt = (ps[0] & ps[1]) ? cmp_v - 12'h001 : cmp_v + 12'h001;
			wr(pfl_pkg::ADDR_CTRL2, {24'h0, ps, ps[1], 3'b000});
			wr(pfl_pkg::ADDR_CMP_LO, {24'h0, cmp_v[7:0]});
			wr(pfl_pkg::ADDR_CMP_HI, {28'h0, cmp_v[11:8]});
			wait_ps(1);
			pulses = 0;
			wait_ps(2 * (int'(ps) + 1));
			`CHK("pulses", 2, pulses)
		end
		// zero compare suppresses triggers; old setup kept until it loads
		wr(pfl_pkg::ADDR_CMP_LO, 32'h0);
		wait_ps(1);
		wr(pfl_pkg::ADDR_CTRL2, 32'h0000_0000);
		pulses = 0;
		wait_ps(2);
		`CHK("pulses", 0, pulses)
		give_verdict();
	end
endmodule : tb_pwm_fault_lockout_trigger
